// [design/eics_regs.vh]
// Constants of the enclave initialisation check sequencer.
`ifndef EICS_REGS_VH
`define EICS_REGS_VH
`define EICS_ALIGN_ECS_BITS   4'hC
`define EICS_ALIGN_TOKEN_BITS 4'h9
`define EICS_SIG_BYTES        12'h710
`define EICS_TOKEN_BYTES      12'h130
`define EICS_PAD_SAVE_BYTES   12'h160
`define EICS_CMAC_BYTES       12'h0C0
`define EICS_HASH_BLOCK_BITS  12'h200
`define EICS_PAD_HEAD         16'h0100
`define EICS_PAD_ONES_BYTES   12'h14A
`define EICS_CTRL_ATTR_MASK   128'h00000000000000000000000000000020
`define EICS_DEBUG_BIT        1
`define EICS_OK               64'h0000000000000000
`define EICS_ERR_UNMASKED     64'h0000000000000001
`define EICS_ERR_SIGNATURE    64'h0000000000000002
`define EICS_ERR_MEASUREMENT  64'h0000000000000003
`define EICS_ERR_ATTRIBUTE    64'h0000000000000004
`define EICS_ERR_TOKEN        64'h0000000000000005
`define EICS_ERR_SEC_VERSION  64'h0000000000000006
`define EICS_ERR_TOKEN_ATTR   64'h0000000000000007
`define EICS_CMD_NONE         3'h0
`define EICS_CMD_COPY         3'h1
`define EICS_CMD_SIG_VERIFY   3'h2
`define EICS_CMD_FINALISE     3'h3
`define EICS_CMD_SIGNER_HASH  3'h4
`define EICS_CMD_KEY_CMAC     3'h5
`endif

// [design/eics_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module eics_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg q1;
  reg q2;
  reg q3;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1   <= 1'b0;
      q2   <= 1'b0;
      q3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      q1 <= din;
      q2 <= q1;
      q3 <= q2;
      if (q2 == q3) begin
        dout <= q3;
      end
    end
  end
endmodule
`default_nettype wire

// [design/eics_sequencer.v]
// Enclave initialisation check sequencer.
// What this block does
// R1: Structure and control addresses need 4KByte alignment.
// R2: Launch token address needs 512Byte alignment.
// R3: Control structure outside page cache: page fault.
// R4: Pending interrupt in signature window exits early.
// R5: Failed signature verify returns bad signature.
// R6: Concurrent modification of control structure: protection fault.
// R7: Map entry valid, control type, not initialised.
// R8: Finalised measurement must match signed hash.
// R9: Controlled attributes need signer equal launch key.
// R10: Masked enclave attributes equal masked signed attributes.
// R11: Masked misc select equals signed misc select.
// R12: Invalid token needs launch signer, then commit.
// R13: Debug token cannot launch production enclave.
// R14: Token reserved regions must be zero.
// R15: Token security version above processor: error.
// R16: Launch key derived from fixed dependency record.
// R17: Token code must match CMAC over 192 bytes.
// R18: Token measurement and signer must match computed.
// R19: Token attributes must equal enclave attributes.
// R20: Commit fields, mark initialised, result zero.
// R21: Exits through S_EXIT clear arithmetic flags; errors there set zero.
// R22: Copy signature structure and token before checks.
// R23: Checks in order, first failure exits, no writes.
`timescale 1ns/1ps
`default_nettype none
`include "eics_regs.vh"
module eics_sequencer #(
  parameter ADDR_W = 64
) (
  input  wire                ref_clk,
  input  wire                rst_b,
  input  wire                start,
  input  wire [ADDR_W-1:0]   sig_addr,
  input  wire [ADDR_W-1:0]   ecs_addr,
  input  wire [ADDR_W-1:0]   token_addr,
  input  wire                ecs_in_cache,
  input  wire                map_valid,
  input  wire                map_is_ecs,
  input  wire                ecs_initialised,
  input  wire                ecs_busy,
  input  wire                meas_busy,
  input  wire                init_busy,
  input  wire                irq_pending,
  input  wire                eng_done,
  input  wire                sig_verified,
  input  wire [255:0]        final_meas,
  input  wire [255:0]        signer_hash,
  input  wire [255:0]        launch_key_hash,
  input  wire [255:0]        sig_enclave_hash,
  input  wire [127:0]        ecs_attr,
  input  wire [127:0]        sig_attr,
  input  wire [127:0]        sig_attr_mask,
  input  wire [31:0]         ecs_misc,
  input  wire [31:0]         sig_misc,
  input  wire [31:0]         sig_misc_mask,
  input  wire [15:0]         sig_prod_id,
  input  wire [15:0]         sig_svn,
  input  wire [31:0]         tok_valid,
  input  wire                tok_rsvd_nonzero,
  input  wire [127:0]        tok_masked_attr,
  input  wire [127:0]        tok_svn,
  input  wire [127:0]        proc_svn,
  input  wire                cmac_match,
  input  wire [255:0]        tok_meas,
  input  wire [255:0]        tok_signer,
  input  wire [127:0]        tok_attr,
  output wire                eng_start,
  output reg  [2:0]          eng_cmd,
  output reg  [11:0]         eng_len,
  output wire [15:0]         kd_pad_head,
  output wire [11:0]         kd_pad_ones_bytes,
  output reg  [255:0]        kd_meas_seed,
  output reg  [31:0]         kd_update_bits,
  input  wire [31:0]         update_count,
  output reg                 pad_save,
  output wire                busy,
  output reg                 done,
  output reg                 gp_fault,
  output reg                 pf_fault,
  output reg  [ADDR_W-1:0]   fault_addr,
  output reg                 zero_flag,
  output reg  [4:0]          arith_flags,
  output reg  [63:0]         result_register,
  output reg                 commit_we,
  output reg                 set_initialised,
  output reg  [255:0]        commit_meas,
  output reg  [255:0]        commit_signer,
  output reg  [15:0]         commit_prod_id,
  output reg  [15:0]         commit_svn
);
  localparam S_IDLE = 9'h001;
  localparam S_COPY = 9'h002;
  localparam S_SIGV = 9'h004;
  localparam S_LOCK = 9'h008;
  localparam S_FIN  = 9'h010;
  localparam S_SGN  = 9'h020;
  localparam S_TOKC = 9'h040;
  localparam S_KEY  = 9'h080;
  localparam S_EXIT = 9'h100;
  reg          rst_q1;
  reg          rst_n;
  reg  [8:0]   state;
  reg  [8:0]   prev_state;
  reg  [255:0] tmp_meas;
  reg  [255:0] tmp_signer;
  reg  [255:0] signer_le;
  wire         irq_sync;
  integer      i;
  // True when the low bits of an address are all zero.
  function aligned;
    input [ADDR_W-1:0] addr;
    input [3:0]        bits;
    begin
      aligned = ((addr[11:0] & ~(12'hFFF << bits)) == 12'h000);
    end
  endfunction
  function masked_eq;
    input [127:0] a;
    input [127:0] b;
    input [127:0] m;
    begin
      masked_eq = ((a & m) == (b & m));
    end
  endfunction
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end
  eics_sync u_irq_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (irq_pending),
    .dout  (irq_sync)
  );
  assign eng_start = (state != prev_state) &&
                     ((state == S_COPY) || (state == S_SIGV) || (state == S_FIN) ||
                      (state == S_SGN) || (state == S_KEY));
  assign busy              = (state != S_IDLE);
  assign kd_pad_head       = `EICS_PAD_HEAD; // R16
  assign kd_pad_ones_bytes = `EICS_PAD_ONES_BYTES; // R16
  // Stored signer is byte-reversed; in the signer state the engine result is not yet latched.
  always @* begin
    signer_le = 256'h0;
    for (i = 0; i < 32; i = i + 1) begin
      signer_le[i*8 +: 8] = (state == S_SGN) ? signer_hash[(31-i)*8 +: 8] : tmp_signer[(31-i)*8 +: 8];
    end
  end
  always @* begin
    eng_cmd = `EICS_CMD_NONE;
    eng_len = 12'h000;
    case (state)
      S_COPY: begin
        eng_cmd = `EICS_CMD_COPY; // R22
        eng_len = `EICS_SIG_BYTES + `EICS_TOKEN_BYTES;
      end
      S_SIGV: begin
        eng_cmd = `EICS_CMD_SIG_VERIFY;
        eng_len = `EICS_PAD_SAVE_BYTES;
      end
      S_FIN: eng_cmd = `EICS_CMD_FINALISE;
      S_SGN: eng_cmd = `EICS_CMD_SIGNER_HASH;
      S_KEY: begin
        eng_cmd = `EICS_CMD_KEY_CMAC; // R17
        eng_len = `EICS_CMAC_BYTES;
      end
      default: eng_cmd = `EICS_CMD_NONE;
    endcase
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= S_IDLE;
      prev_state      <= S_IDLE;
      done            <= 1'b0;
      gp_fault        <= 1'b0;
      pf_fault        <= 1'b0;
      fault_addr      <= {ADDR_W{1'b0}};
      zero_flag       <= 1'b0;
      arith_flags     <= 5'h00;
      result_register <= `EICS_OK;
      commit_we       <= 1'b0;
      set_initialised <= 1'b0;
      commit_meas     <= 256'h0;
      commit_signer   <= 256'h0;
      commit_prod_id  <= 16'h0000;
      commit_svn      <= 16'h0000;
      tmp_meas        <= 256'h0;
      tmp_signer      <= 256'h0;
      pad_save        <= 1'b0;
      kd_meas_seed    <= 256'h0;
      kd_update_bits  <= 32'h00000000;
    end else begin
      prev_state      <= state;
      done            <= 1'b0;
      gp_fault        <= 1'b0;
      pf_fault        <= 1'b0;
      commit_we       <= 1'b0; // R23
      set_initialised <= 1'b0;
      pad_save        <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            if (!aligned(sig_addr, `EICS_ALIGN_ECS_BITS) ||
                !aligned(ecs_addr, `EICS_ALIGN_ECS_BITS)) begin
              gp_fault   <= 1'b1; // R1
              fault_addr <= {ADDR_W{1'b0}};
              done       <= 1'b1;
            end else if (!aligned(token_addr, `EICS_ALIGN_TOKEN_BITS)) begin
              gp_fault   <= 1'b1; // R2
              fault_addr <= {ADDR_W{1'b0}};
              done       <= 1'b1;
            end else if (!ecs_in_cache) begin
              pf_fault   <= 1'b1; // R3
              fault_addr <= ecs_addr;
              done       <= 1'b1;
            end else begin
              state <= S_COPY; // R22
            end
          end
        end
        S_COPY: if (eng_done) state <= S_SIGV;
        S_SIGV: begin
          if (irq_sync) begin
            zero_flag       <= 1'b1; // R4
            result_register <= `EICS_ERR_UNMASKED;
            state           <= S_EXIT;
          end else if (eng_done && !sig_verified) begin
            zero_flag       <= 1'b1; // R5
            result_register <= `EICS_ERR_SIGNATURE;
            state           <= S_EXIT;
          end else if (eng_done) begin
            pad_save <= 1'b1; // R5
            state    <= S_LOCK;
          end
        end
        S_LOCK: begin
          if (ecs_busy || !map_valid || !map_is_ecs || meas_busy || init_busy || ecs_initialised) begin
            fault_addr <= {ADDR_W{1'b0}};
            done       <= 1'b1;
            state      <= S_IDLE;
          end
          if (ecs_busy) begin
            gp_fault <= 1'b1; // R6
          end else if (!map_valid || !map_is_ecs) begin
            pf_fault   <= 1'b1; // R7
            fault_addr <= ecs_addr;
          end else if (meas_busy || init_busy || ecs_initialised) begin
            gp_fault <= 1'b1; // R6 R7
          end else begin
            kd_update_bits <= update_count * {20'h00000, `EICS_HASH_BLOCK_BITS}; // R8
            state          <= S_FIN;
          end
        end
        S_FIN: begin
          if (eng_done) begin
            tmp_meas <= final_meas;
            if (final_meas != sig_enclave_hash) begin
              zero_flag       <= 1'b1; // R8
              result_register <= `EICS_ERR_MEASUREMENT;
              state           <= S_EXIT;
            end else begin
              state <= S_SGN;
            end
          end
        end
        S_SGN: begin
          if (eng_done) begin
            tmp_signer <= signer_hash;
            if (((ecs_attr & `EICS_CTRL_ATTR_MASK) != 128'h0) &&
                (signer_hash != launch_key_hash)) begin
              zero_flag       <= 1'b1; // R9
              result_register <= `EICS_ERR_ATTRIBUTE;
              state           <= S_EXIT;
            end else if (!masked_eq(ecs_attr, sig_attr, sig_attr_mask)) begin
              zero_flag       <= 1'b1; // R10
              result_register <= `EICS_ERR_ATTRIBUTE;
              state           <= S_EXIT;
            end else if (!masked_eq({96'h0, ecs_misc}, {96'h0, sig_misc},
                                    {96'h0, sig_misc_mask})) begin
              zero_flag       <= 1'b1; // R11
              result_register <= `EICS_ERR_ATTRIBUTE;
              state           <= S_EXIT;
            end else if (!tok_valid[0] && (signer_hash != launch_key_hash)) begin
              zero_flag       <= 1'b1; // R12
              result_register <= `EICS_ERR_TOKEN;
              state           <= S_EXIT;
            end else if (!tok_valid[0]) begin
              commit_we       <= 1'b1; // R12 R20
              set_initialised <= 1'b1;
              commit_meas     <= tmp_meas;
              commit_signer   <= signer_le; // R20
              commit_prod_id  <= sig_prod_id;
              commit_svn      <= sig_svn;
              zero_flag       <= 1'b0;
              result_register <= `EICS_OK;
              state           <= S_EXIT;
            end else begin
              state <= S_TOKC;
            end
          end
        end
        S_TOKC: begin
          if (tok_masked_attr[`EICS_DEBUG_BIT] && !ecs_attr[`EICS_DEBUG_BIT]) begin
            zero_flag       <= 1'b1; // R13
            result_register <= `EICS_ERR_TOKEN;
            state           <= S_EXIT;
          end else if (tok_rsvd_nonzero || (tok_valid[31:1] != 31'h0)) begin
            zero_flag       <= 1'b1; // R14
            result_register <= `EICS_ERR_TOKEN;
            state           <= S_EXIT;
          end else if (tok_svn > proc_svn) begin
            zero_flag       <= 1'b1; // R15
            result_register <= `EICS_ERR_SEC_VERSION;
            state           <= S_EXIT;
          end else begin
            kd_meas_seed <= 256'h0; // R16
            state        <= S_KEY;
          end
        end
        S_KEY: begin
          if (eng_done) begin
            if (!cmac_match) begin
              zero_flag       <= 1'b1; // R17
              result_register <= `EICS_ERR_TOKEN;
              state           <= S_EXIT;
            end else if ((tok_meas != tmp_meas) || (tok_signer != tmp_signer)) begin
              zero_flag       <= 1'b1; // R18
              result_register <= `EICS_ERR_MEASUREMENT;
              state           <= S_EXIT;
            end else if (tok_attr != ecs_attr) begin
              zero_flag       <= 1'b1; // R19
              result_register <= `EICS_ERR_TOKEN_ATTR;
              state           <= S_EXIT;
            end else begin
              commit_we       <= 1'b1; // R20
              set_initialised <= 1'b1;
              commit_meas     <= tmp_meas;
              commit_prod_id  <= sig_prod_id;
              commit_svn      <= sig_svn;
              commit_signer   <= signer_le; // R20
              zero_flag       <= 1'b0;
              result_register <= `EICS_OK;
              state           <= S_EXIT;
            end
          end
        end
        S_EXIT: begin
          arith_flags <= 5'h00; // R21
          done        <= 1'b1;
          state       <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/eics_seq_props.sv]
// Assertion checker on the ports of the enclave initialisation check sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "eics_regs.vh"
module eics_seq_props #(
  parameter ADDR_W = 64
) (
  input wire logic                ref_clk,
  input wire logic                rst_b,
  input wire logic                start,
  input wire logic                busy,
  input wire logic [ADDR_W-1:0]   sig_addr,
  input wire logic [ADDR_W-1:0]   ecs_addr,
  input wire logic [ADDR_W-1:0]   token_addr,
  input wire logic                ecs_in_cache,
  input wire logic [255:0]        signer_hash,
  input wire logic                eng_start,
  input wire logic [2:0]          eng_cmd,
  input wire logic [11:0]         eng_len,
  input wire logic [15:0]         kd_pad_head,
  input wire logic [11:0]         kd_pad_ones_bytes,
  input wire logic                done,
  input wire logic                gp_fault,
  input wire logic                pf_fault,
  input wire logic [ADDR_W-1:0]   fault_addr,
  input wire logic                zero_flag,
  input wire logic [4:0]          arith_flags,
  input wire logic [63:0]         result_register,
  input wire logic                commit_we,
  input wire logic                set_initialised,
  input wire logic [255:0]        commit_signer
);
  wire logic [255:0] signer_rev;
  wire logic         go;
  wire logic         big_ok;
  assign signer_rev = {<<8{signer_hash}};
  assign go = start && !busy;
  assign big_ok = sig_addr[11:0] == 12'h000 && ecs_addr[11:0] == 12'h000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_align_fault: assert property (go && !big_ok |=> gp_fault && done && fault_addr == '0)
    else $error("misaligned structure address not faulted");
  a_token_align: assert property (go && big_ok && token_addr[8:0] != 9'h000 |=> gp_fault && done)
    else $error("misaligned token address not faulted");
  a_cache_fault: assert property (go && big_ok && token_addr[8:0] == 9'h000 && !ecs_in_cache
    |=> pf_fault && done && fault_addr == ecs_addr)
    else $error("page fault missing or wrong address");
  a_copy_first: assert property (go && big_ok && token_addr[8:0] == 9'h000 && ecs_in_cache
    |=> eng_start && eng_cmd == `EICS_CMD_COPY && eng_len == (`EICS_SIG_BYTES + `EICS_TOKEN_BYTES) && !done)
    else $error("copy of both structures not started");
  a_sig_len: assert property (eng_cmd == `EICS_CMD_SIG_VERIFY |-> eng_len == `EICS_PAD_SAVE_BYTES)
    else $error("signature padding length wrong");
  a_key_pad: assert property (eng_cmd == `EICS_CMD_KEY_CMAC |-> eng_len == `EICS_CMAC_BYTES
    && kd_pad_head == `EICS_PAD_HEAD && kd_pad_ones_bytes == `EICS_PAD_ONES_BYTES)
    else $error("key derivation padding or code length wrong");
  a_commit_exit: assert property (commit_we |-> set_initialised && !zero_flag && result_register == `EICS_OK
    ##1 done && !commit_we)
    else $error("commit not followed by clean exit");
  a_signer_order: assert property (commit_we |-> commit_signer == signer_rev)
    else $error("committed signer not byte reversed");
  a_exit_flags: assert property (done && !gp_fault && !pf_fault
    |-> arith_flags == 5'h00 && zero_flag == (result_register != `EICS_OK))
    else $error("exit flags do not match result");
  a_fault_quiet: assert property (gp_fault || pf_fault
    |-> done && !commit_we && $stable(zero_flag) && $stable(result_register))
    else $error("fault touched result or committed");
endmodule
bind eics_sequencer eics_seq_props #(.ADDR_W(ADDR_W)) eics_seq_props_inst (.*);
`default_nettype wire

// [dv/eics_tb.sv]
// Self-checking bench of the enclave initialisation check sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "eics_regs.vh"
module tb;
  localparam logic [255:0] mh = {8{32'hA5A50001}};
  localparam logic [255:0] sh = {16{16'h1234}};
  localparam logic [255:0] lh = {8{32'hC3C30003}};
  logic         ref_clk, rst_b, start, ecs_in_cache, map_valid, map_is_ecs, ecs_initialised;
  logic         ecs_busy, meas_busy, init_busy, irq_pending, sig_verified, tok_rsvd_nonzero, cmac_match;
  logic         eng_start, pad_save, busy, done, gp_fault, pf_fault, zero_flag, commit_we, set_initialised;
  logic         eng_done = 1'b0;
  logic [63:0]  sig_addr, ecs_addr, token_addr, fault_addr, result_register;
  logic [255:0] final_meas, signer_hash, launch_key_hash, sig_enclave_hash, tok_meas, tok_signer;
  logic [255:0] kd_meas_seed, commit_meas, commit_signer;
  logic [127:0] ecs_attr, sig_attr, sig_attr_mask, tok_masked_attr, tok_svn, proc_svn, tok_attr;
  logic [31:0]  ecs_misc, sig_misc, sig_misc_mask, tok_valid, kd_update_bits, update_count;
  logic [15:0]  sig_prod_id, sig_svn, kd_pad_head, commit_prod_id, commit_svn;
  logic [11:0]  eng_len, kd_pad_ones_bytes;
  logic [4:0]   arith_flags;
  logic [2:0]   eng_cmd;
  int           n_mismatch = 0;
  int           n_checks = 0;
  int           eng_cnt = 0;
  eics_sequencer eics_sequencer_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Stand-in for the crypto engine: answers each command five cycles after it starts.
  always @(posedge ref_clk) begin
    if (eng_start === 1'b1) eng_cnt <= 5;
    else if (eng_cnt != 0) eng_cnt <= eng_cnt - 1;
    eng_done <= (eng_cnt == 1);
  end
  task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic base;
    sig_addr <= 64'h10000;
    ecs_addr <= 64'h20000;
    token_addr <= 64'h30200;
    {ecs_in_cache, map_valid, map_is_ecs, sig_verified, cmac_match} <= 5'h1F;
    {ecs_initialised, ecs_busy, meas_busy, init_busy, irq_pending, tok_rsvd_nonzero} <= 6'h00;
    final_meas <= mh;
    sig_enclave_hash <= mh;
    tok_meas <= mh;
    signer_hash <= sh;
    tok_signer <= sh;
    launch_key_hash <= lh;
    ecs_attr <= 128'h2;
    sig_attr <= 128'h2;
    tok_attr <= 128'h2;
    sig_attr_mask <= 128'hFF;
    tok_masked_attr <= 128'h0;
    tok_svn <= 128'h1;
    proc_svn <= 128'h1;
    ecs_misc <= 32'h0;
    sig_misc <= 32'h0;
    sig_misc_mask <= 32'hFFFFFFFF;
    tok_valid <= 32'h1;
    update_count <= 32'h3;
    sig_prod_id <= 16'h0042;
    sig_svn <= 16'h0007;
  endtask
  task automatic run(input int idx);
    int          ek;
    logic [63:0] ec;
    int          cw;
    int          n;
    int          ps;
    @(posedge ref_clk);
    base;
    ek = 0;
    ec = `EICS_OK;
    cw = 0;
    ps = 0;
    case (idx)
      1: begin ecs_addr <= 64'h21800; ek = 2; end
      2: begin sig_addr <= 64'h10040; ek = 2; end
      3: begin token_addr <= 64'h30100; ek = 2; end
      4: begin ecs_in_cache <= 1'b0; ek = 3; end
      5: begin sig_verified <= 1'b0; ec = `EICS_ERR_SIGNATURE; end
      6: begin ecs_busy <= 1'b1; ek = 2; end
      7: begin map_valid <= 1'b0; ek = 3; end
      8: begin map_is_ecs <= 1'b0; ek = 3; end
      9: begin ecs_initialised <= 1'b1; ek = 2; end
      10: begin meas_busy <= 1'b1; ek = 2; end
      11: begin init_busy <= 1'b1; ek = 2; end
      12: begin final_meas <= lh; ec = `EICS_ERR_MEASUREMENT; end
      13: begin
        ecs_attr <= 128'h22;
        sig_attr <= 128'h22;
        ec = `EICS_ERR_ATTRIBUTE;
      end
      14: begin sig_attr <= 128'h3; ec = `EICS_ERR_ATTRIBUTE; end
      15: begin sig_misc <= 32'h1; ec = `EICS_ERR_ATTRIBUTE; end
      16: begin tok_valid <= 32'h0; launch_key_hash <= sh; end
      17: begin tok_valid <= 32'h0; ec = `EICS_ERR_TOKEN; end
      18: begin
        ecs_attr <= 128'h0;
        sig_attr <= 128'h0;
        tok_attr <= 128'h0;
        tok_masked_attr <= 128'h2;
        ec = `EICS_ERR_TOKEN;
      end
      19: begin tok_rsvd_nonzero <= 1'b1; ec = `EICS_ERR_TOKEN; end
      20: begin tok_valid <= 32'h3; ec = `EICS_ERR_TOKEN; end
      21: begin tok_svn <= 128'h2; ec = `EICS_ERR_SEC_VERSION; end
      22: begin cmac_match <= 1'b0; ec = `EICS_ERR_TOKEN; end
      23: begin tok_meas <= lh; ec = `EICS_ERR_MEASUREMENT; end
      24: begin tok_signer <= lh; ec = `EICS_ERR_MEASUREMENT; end
      25: begin tok_attr <= 128'h3; ec = `EICS_ERR_TOKEN_ATTR; end
      26: begin irq_pending <= 1'b1; ec = `EICS_ERR_UNMASKED; end
      default: ;
    endcase
    if (ec != `EICS_OK) ek = 1;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    for (n = 0; n < 300 && done !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      if (commit_we === 1'b1) cw++;
      if (pad_save === 1'b1) ps++;
    end
    if (n == 300) begin
      n_mismatch++;
      test_done;
    end
    chk("gp_fault", ek == 2, gp_fault);
    chk("pf_fault", ek == 3, pf_fault);
    if (ek >= 2) chk("fault_addr", (ek == 3) ? ecs_addr : 64'h0, fault_addr);
    else begin
      chk("zero_flag", ek == 1, zero_flag);
      chk("result", ec, result_register);
      chk("arith_flags", 5'h00, arith_flags);
    end
    chk("commits", ek == 0, cw);
    chk("pad_save", (idx == 0) || ((idx > 5) && (idx != 26)), ps);
    if (ek == 0) begin
      chk("signer", {16{16'h3412}}, commit_signer);
      chk("meas", mh, commit_meas);
      chk("prod_id", 16'h0042, commit_prod_id);
      chk("svn", 16'h0007, commit_svn);
      chk("update_bits", 32'h600, kd_update_bits);
      chk("meas_seed", 256'h0, kd_meas_seed);
    end
    $display("case %0d finished", idx);
  endtask
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    base;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 27; i++) run(i);
    test_done;
  end
endmodule
`default_nettype wire
